// [src/btav_pkg.sv]
/*
 * Package for the BCD time and alarm value windows: APB offsets, field
 * positions, masks, pointer codes, reset values and unlock keys.
 * Assumes a 32-bit APB slave with word-aligned registers.
 */
package btav_pkg;
    // ========================================================================
    // Register byte offsets
    localparam logic [7:0] BTAV_OFF_TIME_WIN = 8'h00;
    localparam logic [7:0] BTAV_OFF_ALARM_WIN = 8'h04;
    localparam logic [7:0] BTAV_OFF_CTRL = 8'h08;
    localparam logic [7:0] BTAV_OFF_KEY = 8'h0C;
    localparam logic [7:0] BTAV_OFF_IRQ_STAT = 8'h10;
    localparam logic [7:0] BTAV_OFF_IRQ_MASK = 8'h14;
    // ========================================================================
    // Control register fields
    localparam int BTAV_CTRL_WREN_BIT = 0;
    localparam int BTAV_CTRL_TPTR_LSB = 8;
    localparam int BTAV_CTRL_APTR_LSB = 12;
    // ========================================================================
    // Window pointer codes
    localparam logic [1:0] BTAV_PTR_MINSEC = 2'h0;
    localparam logic [1:0] BTAV_PTR_WDHR = 2'h1;
    localparam logic [1:0] BTAV_PTR_MTHDAY = 2'h2;
    localparam logic [1:0] BTAV_PTR_YEAR = 2'h3;
    // ========================================================================
    // Implemented-bit masks per layout; all other bits read zero
    localparam logic [15:0] BTAV_MASK_YEAR = 16'h00FF;
    localparam logic [15:0] BTAV_MASK_MTHDAY = 16'h1F3F;
    localparam logic [15:0] BTAV_MASK_WDHR = 16'h073F;
    localparam logic [15:0] BTAV_MASK_MINSEC = 16'h7F7F;
    // ========================================================================
    // Reset values: 01 Jan 00, weekday 0, 00:00:00
    localparam logic [15:0] BTAV_RST_YEAR = 16'h0000;
    localparam logic [15:0] BTAV_RST_MTHDAY = 16'h0101;
    localparam logic [15:0] BTAV_RST_WDHR = 16'h0000;
    localparam logic [15:0] BTAV_RST_MINSEC = 16'h0000;
    // ========================================================================
    // Unlock key bytes
    localparam logic [7:0] BTAV_KEY_FIRST = 8'h55;
    localparam logic [7:0] BTAV_KEY_SECOND = 8'hAA;
    // ========================================================================
    // Tick divider: 10 MHz core clock down to 1 Hz
    localparam int BTAV_CLK_HZ = 10000000;
    localparam int BTAV_TICK_HZ = 1;
    localparam int BTAV_TICK_CYCLES = BTAV_CLK_HZ / BTAV_TICK_HZ;
    // ========================================================================
    // Interrupt status bits
    localparam int BTAV_IRQ_ALARM = 0;
    localparam int BTAV_IRQ_SECOND = 1;
    localparam int BTAV_IRQ_W = 2;
endpackage : btav_pkg

// [src/btav_tick_div.sv]
/*
 * Divider that makes a one-cycle 1 Hz tick enable from the core clock.
 * Assumes a single clock; period is a parameter so simulation can shorten it.
 */
`timescale 1ns/10ps
module btav_tick_div #(
    parameter int PERIOD = btav_pkg::BTAV_TICK_CYCLES
) (
    input wire logic clk_in,      // Core clock
    input wire logic nrst_in,     // Synchronous reset, active low
    input wire logic clr_in,      // Restart the prescaler
    output logic tick_out         // One-cycle tick
);
    import btav_pkg::*;
    logic [23:0] cnt_r;
    logic [23:0] cnt_nxt;
    logic tick_nxt;
    logic tick_r;

    // ========================================================================
    // Counter next state; a clear restarts the second so writes are not cut
    always_comb begin
        cnt_nxt = cnt_r + 24'h00_0001;
        tick_nxt = 1'b0;
        if (clr_in) begin
            cnt_nxt = 24'h00_0000;
        end else if (cnt_r == 24'(PERIOD - 1)) begin
            cnt_nxt = 24'h00_0000;
            tick_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            cnt_r <= 24'h00_0000;
            tick_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            tick_r <= tick_nxt;
        end
    end

    assign tick_out = tick_r;
endmodule : btav_tick_div

// [src/btav_bcd_digit.sv]
/*
 * One BCD counter stage: increments with carry-in, wraps at a top value
 * back to a restart value, and reports carry-out on wrap.
 * Assumes the caller holds the digit register; this is pure logic.
 */
`timescale 1ns/10ps
module btav_bcd_digit (
    input wire logic [3:0] val_in,    // Present digit value
    input wire logic [3:0] top_in,    // Last value before wrap
    input wire logic [3:0] start_in,  // Restart value after wrap
    input wire logic inc_in,          // Carry into this stage
    output logic [3:0] val_out,       // Next digit value
    output logic carry_out            // Wrap happened
);
    // ========================================================================
    // Wrap on reaching top; >= also recovers from out-of-range writes
    always_comb begin
        val_out = val_in;
        carry_out = 1'b0;
        if (inc_in) begin
            if (val_in >= top_in) begin
                val_out = start_in;
                carry_out = 1'b1;
            end else begin
                val_out = val_in + 4'h1;
            end
        end
    end
endmodule : btav_bcd_digit

// [src/btav_rtc.sv]
/*
 * BCD time and alarm value windows with APB access, unlock sequence,
 * 1 Hz calendar advance, alarm compare and a masked interrupt.
 * Assumes APB3 master at 10 MHz on the same clock; synchronous reset.
 */
`timescale 1ns/10ps
module btav_rtc #(
    parameter int TICK_PERIOD = btav_pkg::BTAV_TICK_CYCLES
) (
    input wire logic clk_in,             // Core clock, 10 MHz
    input wire logic nrst_in,            // Synchronous reset, active low
    input wire logic psel_in,            // APB select
    input wire logic penable_in,         // APB enable
    input wire logic pwrite_in,          // APB write
    input wire logic [7:0] paddr_in,     // APB byte address
    input wire logic [31:0] pwdata_in,   // APB write data
    input wire logic [3:0] pstrb_in,     // APB byte strobes
    output logic [31:0] prdata_out,      // APB read data
    output logic pready_out,             // APB ready
    output logic pslverr_out,            // APB error, unmapped address
    output logic alarm_match_out,        // One-cycle alarm event
    output logic irq_out                 // Level interrupt
);
    import btav_pkg::*;

    logic [15:0] time_r [4];
    logic [15:0] alarm_r [3];
    logic [15:0] time_nxt [4];
    logic [15:0] alarm_nxt [3];
    logic [1:0] tptr_r, tptr_nxt, aptr_r, aptr_nxt;
    logic wren_r, wren_nxt;
    logic key1_r, key1_nxt, key2_r, key2_nxt;
    logic [BTAV_IRQ_W-1:0] stat_r, stat_nxt, mask_r, mask_nxt;
    logic match_r, match_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic tick;
    logic pre_clr;
    logic acc, wr, rd, hi_acc, mapped;
    logic [15:0] wmask, tsel, asel, tmask_sel, amask_sel;
    logic [15:0] t_ms, t_wh, t_md, t_yr, adv_ms, adv_wh, adv_md, adv_yr;
    logic c_sec1, c_sec10, c_min1, c_min10, c_hr, c_day, c_mth, c_yr1;
    logic [3:0] s1, s10, m1, m10, y1, y10;
    logic [3:0] day_last, hr_top;
    logic leap;

    // ========================================================================
    // APB decode: zero-wait slave, answers in the access phase
    assign acc = psel_in && penable_in;
    assign wr = acc && pwrite_in;
    assign rd = acc && !pwrite_in;
    assign pready_out = 1'b1;
    assign mapped = (paddr_in == BTAV_OFF_TIME_WIN) || (paddr_in == BTAV_OFF_ALARM_WIN)
                  || (paddr_in == BTAV_OFF_CTRL) || (paddr_in == BTAV_OFF_KEY)
                  || (paddr_in == BTAV_OFF_IRQ_STAT) || (paddr_in == BTAV_OFF_IRQ_MASK);
    assign pslverr_out = acc && !mapped;
    // Reads touch both bytes, so any read counts; writes only via strobe 1
    assign hi_acc = rd || (wr && pstrb_in[1]);
    assign wmask = {{8{pstrb_in[1]}}, {8{pstrb_in[0]}}};

    // ========================================================================
    // Window layouts and selection
    function automatic logic [15:0] lay_mask(input logic [1:0] p);
        logic [15:0] m;
        m = BTAV_MASK_MINSEC;
        unique case (p)
            BTAV_PTR_YEAR: m = BTAV_MASK_YEAR;
            BTAV_PTR_MTHDAY: m = BTAV_MASK_MTHDAY;
            BTAV_PTR_WDHR: m = BTAV_MASK_WDHR;
            BTAV_PTR_MINSEC: m = BTAV_MASK_MINSEC;
        endcase
        return m;
    endfunction : lay_mask

    assign tmask_sel = lay_mask(tptr_r);
    assign amask_sel = lay_mask(aptr_r);
    assign tsel = time_r[tptr_r] & tmask_sel;
    assign asel = (aptr_r == BTAV_PTR_YEAR) ? 16'h0000
                : (alarm_r[aptr_r] & amask_sel);

    // ========================================================================
    // Calendar advance on the tick
    assign t_ms = time_r[BTAV_PTR_MINSEC];
    assign t_wh = time_r[BTAV_PTR_WDHR];
    assign t_md = time_r[BTAV_PTR_MTHDAY];
    assign t_yr = time_r[BTAV_PTR_YEAR];

    btav_bcd_digit u_s1 (.val_in(t_ms[3:0]), .top_in(4'h9), .start_in(4'h0),
        .inc_in(tick), .val_out(s1), .carry_out(c_sec1));
    btav_bcd_digit u_s10 (.val_in({1'b0, t_ms[6:4]}), .top_in(4'h5), .start_in(4'h0),
        .inc_in(c_sec1), .val_out(s10), .carry_out(c_sec10));
    btav_bcd_digit u_m1 (.val_in(t_ms[11:8]), .top_in(4'h9), .start_in(4'h0),
        .inc_in(c_sec10), .val_out(m1), .carry_out(c_min1));
    btav_bcd_digit u_m10 (.val_in({1'b0, t_ms[14:12]}), .top_in(4'h5), .start_in(4'h0),
        .inc_in(c_min1), .val_out(m10), .carry_out(c_min10));
    btav_bcd_digit u_y1 (.val_in(t_yr[3:0]), .top_in(4'h9), .start_in(4'h0),
        .inc_in(c_mth), .val_out(y1), .carry_out(c_yr1));
    btav_bcd_digit u_y10 (.val_in(t_yr[7:4]), .top_in(4'h9), .start_in(4'h0),
        .inc_in(c_yr1), .val_out(y10), .carry_out());

    // Leap year: BCD year divisible by four, valid through 2099
    assign leap = (t_yr[4] == 1'b0) ? (t_yr[1:0] == 2'b00) : (t_yr[1:0] == 2'b10);
    assign hr_top = (t_wh[5:4] == 2'h2) ? 4'h3 : 4'h9;

    // Hours, days and months wrap on full-value compares, not digit stages
    always_comb begin
        day_last = 4'h1;  // Low digit of last day, tens held below
        adv_wh = t_wh;
        adv_md = t_md;
        adv_ms = {1'b0, m10[2:0], m1, 1'b0, s10[2:0], s1};
        adv_yr = {8'h00, y10, y1};
        c_hr = 1'b0;
        c_day = 1'b0;
        c_mth = 1'b0;
        if (c_min10) begin
            if (t_wh[5:0] >= 6'h23) begin
                adv_wh[5:0] = 6'h00;
                c_hr = 1'b1;
            end else if (t_wh[3:0] >= hr_top) begin
                adv_wh[5:0] = {t_wh[5:4] + 2'h1, 4'h0};
            end else begin
                adv_wh[3:0] = t_wh[3:0] + 4'h1;
            end
        end
        if (c_hr) begin
            adv_wh[10:8] = (t_wh[10:8] >= 3'h6) ? 3'h0 : t_wh[10:8] + 3'h1;
            unique case (t_md[12:8])
                5'h02: day_last = leap ? 4'h9 : 4'h8;
                5'h04, 5'h06, 5'h09, 5'h11: day_last = 4'h0;
                default: day_last = 4'h1;
            endcase
            if (t_md[12:8] == 5'h02) begin
                c_day = (t_md[5:0] >= {2'h2, day_last});
            end else begin
                c_day = (t_md[5:0] >= {2'h3, day_last});
            end
            if (c_day) begin
                adv_md[5:0] = 6'h01;
            end else if (t_md[3:0] >= 4'h9) begin
                adv_md[5:0] = {t_md[5:4] + 2'h1, 4'h0};
            end else begin
                adv_md[3:0] = t_md[3:0] + 4'h1;
            end
        end
        if (c_day) begin
            if (t_md[12:8] >= 5'h12) begin
                adv_md[12:8] = 5'h01;
                c_mth = 1'b1;
            end else if (t_md[11:8] >= 4'h9) begin
                adv_md[12:8] = 5'h10;
            end else begin
                adv_md[11:8] = t_md[11:8] + 4'h1;
            end
        end
    end

    // ========================================================================
    // Window next state: software write has priority over the tick
    always_comb begin
        time_nxt[BTAV_PTR_MINSEC] = tick ? adv_ms : t_ms;
        time_nxt[BTAV_PTR_WDHR] = c_min10 ? adv_wh : t_wh;
        time_nxt[BTAV_PTR_MTHDAY] = c_hr ? adv_md : t_md;
        time_nxt[BTAV_PTR_YEAR] = c_mth ? adv_yr : t_yr;
        alarm_nxt = alarm_r;
        if (wr && wren_r && paddr_in == BTAV_OFF_TIME_WIN) begin
            time_nxt[tptr_r] = ((pwdata_in[15:0] & wmask)
                | (time_r[tptr_r] & ~wmask)) & tmask_sel;
        end
        if (wr && wren_r && paddr_in == BTAV_OFF_ALARM_WIN
            && aptr_r != BTAV_PTR_YEAR) begin
            alarm_nxt[aptr_r] = ((pwdata_in[15:0] & wmask)
                | (alarm_r[aptr_r] & ~wmask)) & amask_sel;
        end
    end

    // Prescaler restarts when minutes/seconds are written
    assign pre_clr = wr && wren_r && paddr_in == BTAV_OFF_TIME_WIN
                   && tptr_r == BTAV_PTR_MINSEC;

    // ========================================================================
    // Control, pointers, unlock and interrupt next state
    always_comb begin
        tptr_nxt = tptr_r;
        aptr_nxt = aptr_r;
        wren_nxt = wren_r;
        key1_nxt = key1_r;
        mask_nxt = mask_r;
        stat_nxt = stat_r;
        rdata_nxt = rdata_r;
        match_nxt = tick && (t_ms & BTAV_MASK_MINSEC) == (alarm_r[0] & BTAV_MASK_MINSEC)
                  && (t_wh & BTAV_MASK_WDHR) == (alarm_r[1] & BTAV_MASK_WDHR)
                  && (t_md & BTAV_MASK_MTHDAY) == (alarm_r[2] & BTAV_MASK_MTHDAY);
        if (acc && paddr_in == BTAV_OFF_TIME_WIN && hi_acc && tptr_r != 2'h0) begin
            tptr_nxt = tptr_r - 2'h1;
        end
        if (acc && paddr_in == BTAV_OFF_ALARM_WIN && hi_acc && aptr_r != 2'h0) begin
            aptr_nxt = aptr_r - 2'h1;
        end
        if (wr && paddr_in == BTAV_OFF_KEY && pstrb_in[0]) begin
            key1_nxt = (pwdata_in[7:0] == BTAV_KEY_FIRST);
        end else if (wr) begin
            key1_nxt = 1'b0;  // Any other write breaks the sequence
        end
        if (wr && paddr_in == BTAV_OFF_CTRL) begin
            if (pstrb_in[0]) begin
                // Set only when the previous write was the second key
                if (!pwdata_in[BTAV_CTRL_WREN_BIT]) begin
                    wren_nxt = 1'b0;
                end else if (key2_r) begin
                    wren_nxt = 1'b1;
                end
            end
            if (pstrb_in[1]) begin
                tptr_nxt = pwdata_in[BTAV_CTRL_TPTR_LSB +: 2];
                aptr_nxt = pwdata_in[BTAV_CTRL_APTR_LSB +: 2];
            end
        end
        if (wr && paddr_in == BTAV_OFF_IRQ_MASK && pstrb_in[0]) begin
            mask_nxt = pwdata_in[BTAV_IRQ_W-1:0];
        end
        if (wr && paddr_in == BTAV_OFF_IRQ_STAT && pstrb_in[0]) begin
            stat_nxt = stat_r & ~pwdata_in[BTAV_IRQ_W-1:0];
        end
        // Events set after the clear so the set wins in the same cycle
        if (match_r) begin
            stat_nxt[BTAV_IRQ_ALARM] = 1'b1;
        end
        if (tick) begin
            stat_nxt[BTAV_IRQ_SECOND] = 1'b1;
        end
        if (rd) begin
            unique case (paddr_in)
                BTAV_OFF_TIME_WIN: rdata_nxt = {16'h0000, tsel};
                BTAV_OFF_ALARM_WIN: rdata_nxt = {16'h0000, asel};
                BTAV_OFF_CTRL: rdata_nxt = {18'h0_0000, aptr_r, 2'b00, tptr_r,
                                            7'h00, wren_r};
                BTAV_OFF_IRQ_STAT: rdata_nxt = {30'h0000_0000, stat_r};
                BTAV_OFF_IRQ_MASK: rdata_nxt = {30'h0000_0000, mask_r};
                default: rdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    // Key2 latch: a write of the second key after the first arms the enable
    always_comb begin
        key2_nxt = key2_r;
        if (wr) begin
            key2_nxt = (paddr_in == BTAV_OFF_KEY) && pstrb_in[0] && key1_r
                     && (pwdata_in[7:0] == BTAV_KEY_SECOND);
        end
    end

    // ========================================================================
    // Registers
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            time_r[BTAV_PTR_MINSEC] <= BTAV_RST_MINSEC;
            time_r[BTAV_PTR_WDHR] <= BTAV_RST_WDHR;
            time_r[BTAV_PTR_MTHDAY] <= BTAV_RST_MTHDAY;
            time_r[BTAV_PTR_YEAR] <= BTAV_RST_YEAR;
            alarm_r[0] <= BTAV_RST_MINSEC;
            alarm_r[1] <= BTAV_RST_WDHR;
            alarm_r[2] <= BTAV_RST_MTHDAY;
            tptr_r <= 2'h0;
            aptr_r <= 2'h0;
            wren_r <= 1'b0;
            key1_r <= 1'b0;
            key2_r <= 1'b0;
            stat_r <= '0;
            mask_r <= '0;
            match_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
        end else begin
            time_r <= time_nxt;
            alarm_r <= alarm_nxt;
            tptr_r <= tptr_nxt;
            aptr_r <= aptr_nxt;
            wren_r <= wren_nxt;
            key1_r <= key1_nxt;
            key2_r <= key2_nxt;
            stat_r <= stat_nxt;
            mask_r <= mask_nxt;
            match_r <= match_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // Read data must be valid in the access phase, so read mux is combinational
    assign prdata_out = rd ? rdata_nxt : rdata_r;
    assign alarm_match_out = match_r;
    assign irq_out = |(stat_r & mask_r);

    btav_tick_div #(.PERIOD(TICK_PERIOD)) u_div (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .clr_in(pre_clr),
        .tick_out(tick)
    );

    // ========================================================================
    // Checks
    a_locked_write_held: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (wr && !wren_r && paddr_in == BTAV_OFF_ALARM_WIN) |=> $stable(alarm_r[0])
        && $stable(alarm_r[1]) && $stable(alarm_r[2]))
        else $error("alarm window changed while locked");
    a_ptr_stops_zero: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (rd && paddr_in == BTAV_OFF_TIME_WIN && tptr_r == 2'h0) |=> tptr_r == 2'h0)
        else $error("time pointer moved below zero");
    a_ptr_decrement: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (rd && paddr_in == BTAV_OFF_ALARM_WIN && aptr_r != 2'h0)
        |=> aptr_r == $past(aptr_r) - 2'h1)
        else $error("alarm pointer did not decrement");
    a_unused_bits_zero: assert property (@(posedge clk_in) disable iff (!nrst_in)
        rd && paddr_in == BTAV_OFF_TIME_WIN |-> (prdata_out[15:0] & ~tmask_sel) == 16'h0000)
        else $error("unimplemented bits read nonzero");
    a_wren_needs_keys: assert property (@(posedge clk_in) disable iff (!nrst_in)
        $rose(wren_r) |-> $past(key2_r))
        else $error("write enable set without key sequence");
    a_year_range: assert property (@(posedge clk_in) disable iff (!nrst_in)
        time_r[BTAV_PTR_YEAR][15:8] == 8'h00)
        else $error("year upper byte not zero");
    a_second_wrap: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (tick && !pre_clr && t_ms[6:0] == 7'h59 && !(wr && paddr_in == BTAV_OFF_TIME_WIN))
        |=> time_r[BTAV_PTR_MINSEC][6:0] == 7'h00)
        else $error("seconds did not wrap to zero");
    a_match_event: assert property (@(posedge clk_in) disable iff (!nrst_in)
        match_r |=> stat_r[BTAV_IRQ_ALARM])
        else $error("alarm match not recorded");
endmodule : btav_rtc

// [tb/test_btav_rtc.sv]
/* Self-checking bench for btav_rtc: APB master tasks, window writes and reads.
   Assumes any APB wait count up to a bound, and a tick period of 40 core cycles. */
`timescale 1ns/10ps
module test_btav_rtc;
    import btav_pkg::*;
    // ========================================
    // Stimulus and observation signals
    localparam logic [31:0] ALL = 32'hFFFF_FFFF;
    logic clk_in = 1'b0;
    logic nrst_in = 1'b0;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic [7:0] pa = 8'h00;
    logic [31:0] pwd = 32'h0000_0000;
    logic [3:0] ps = 4'h0;
    logic [31:0] prdata;
    logic pready, pslverr, alarm, irq, se;
    logic seen = 1'b0;
    logic [31:0] rd;
    int error_cnt = 0;
    int cmp_count = 0;
    int i;
    logic [31:0] tw[4] = '{32'h0000_FF99, 32'h0000_F231, 32'h0000_FE23, 32'h0000_D9D9};
    logic [31:0] te[4] = '{32'h0000_0099, 32'h0000_1231, 32'h0000_0623, 32'h0000_5959};
    logic [31:0] re[4] = '{32'h0000_0000, 32'h0000_0101, 32'h0000_0000, 32'h0000_0000};

    btav_rtc #(.TICK_PERIOD(40)) btav_rtc_i (.clk_in(clk_in), .nrst_in(nrst_in),
        .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(pa),
        .pwdata_in(pwd), .pstrb_in(ps), .prdata_out(prdata), .pready_out(pready),
        .pslverr_out(pslverr), .alarm_match_out(alarm), .irq_out(irq));

    // 10 MHz core clock
    initial begin
        forever #50 clk_in = ~clk_in;
    end
    // ========================================
    // Verdict, compare and bus tasks
    task test_done;
        $display("errors %0d compares %0d", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : test_done
    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Request held until the rising edge that sees pready high; answer taken there
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        @(posedge clk_in);
        psel <= 1'b1;
        pwr <= w;
        pa <= a;
        pwd <= d;
        ps <= s;
        @(posedge clk_in);
        pen <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_in);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            chk(32'h0000_0000, 32'h0000_0001);
            test_done;
        end
        rd = prdata;
        se = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : apb
    task rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000, 4'h0);
        chk(rd & m, e);
    endtask : rdc
    // Interrupt may lag a register write by one cycle, so allow two
    task chki(input logic e);
        repeat (2) @(negedge clk_in);
        chk({31'h0000_0000, irq}, {31'h0000_0000, e});
    endtask : chki
    // ========================================
    // Main sequence
    initial begin
        repeat (16) @(posedge clk_in);
        nrst_in <= 1'b1;
        rdc(BTAV_OFF_CTRL, 32'h0000_3301, 32'h0000_0000);
        apb(1'b1, BTAV_OFF_CTRL, 32'h0000_0300, 4'h3);
        apb(1'b1, BTAV_OFF_TIME_WIN, 32'h0000_0042, 4'hF);
        apb(1'b1, BTAV_OFF_CTRL, 32'h0000_0300, 4'h3);
        rdc(BTAV_OFF_TIME_WIN, ALL, 32'h0000_0000);
        apb(1'b1, BTAV_OFF_KEY, 32'h0000_0055, 4'h1);
        apb(1'b1, BTAV_OFF_KEY, 32'h0000_00AA, 4'h1);
        apb(1'b1, BTAV_OFF_CTRL, 32'h0000_2301, 4'h3);
        rdc(BTAV_OFF_CTRL, 32'h0000_3301, 32'h0000_2301);
        for (i = 1; i < 4; i++) apb(1'b1, BTAV_OFF_ALARM_WIN, tw[i], 4'hF);
        apb(1'b1, BTAV_OFF_CTRL, 32'h0000_2301, 4'h3);
        for (i = 1; i < 4; i++) rdc(BTAV_OFF_ALARM_WIN, ALL, te[i]);
        rdc(BTAV_OFF_ALARM_WIN, ALL, te[3]);
        apb(1'b1, BTAV_OFF_CTRL, 32'h0000_3301, 4'h3);
        rdc(BTAV_OFF_ALARM_WIN, ALL, 32'h0000_0000);
        rdc(BTAV_OFF_ALARM_WIN, ALL, te[1]);
        apb(1'b1, BTAV_OFF_CTRL, 32'h0000_0301, 4'h3);
        for (i = 0; i < 4; i++) apb(1'b1, BTAV_OFF_TIME_WIN, tw[i], 4'hF);
        apb(1'b1, BTAV_OFF_CTRL, 32'h0000_0301, 4'h3);
        for (i = 0; i < 4; i++) rdc(BTAV_OFF_TIME_WIN, ALL, te[i]);
        // Stale second and alarm status bits are cleared before unmasking
        apb(1'b1, BTAV_OFF_IRQ_STAT, 32'h0000_0003, 4'hF);
        apb(1'b1, BTAV_OFF_IRQ_MASK, 32'h0000_0001, 4'hF);
        // The match pulse lasts one cycle, so it is watched at every edge of the wait
        for (i = 0; i < 200 && irq !== 1'b1; i++) begin
            @(posedge clk_in);
            if (alarm === 1'b1) seen = 1'b1;
        end
        chk({31'h0000_0000, irq}, 32'h0000_0001);
        if (irq !== 1'b1) test_done;
        chk({31'h0000_0000, seen}, 32'h0000_0001);
        rdc(BTAV_OFF_IRQ_STAT, 32'h0000_0001, 32'h0000_0001);
        apb(1'b1, BTAV_OFF_CTRL, 32'h0000_0301, 4'h3);
        for (i = 0; i < 4; i++) rdc(BTAV_OFF_TIME_WIN, ALL, re[i]);
        apb(1'b1, BTAV_OFF_IRQ_MASK, 32'h0000_0000, 4'hF);
        chki(1'b0);
        apb(1'b1, BTAV_OFF_IRQ_MASK, 32'h0000_0001, 4'hF);
        chki(1'b1);
        apb(1'b1, BTAV_OFF_IRQ_STAT, 32'h0000_0001, 4'hF);
        chki(1'b0);
        apb(1'b1, BTAV_OFF_CTRL, 32'h0000_0300, 4'h3);
        apb(1'b1, BTAV_OFF_TIME_WIN, 32'h0000_0042, 4'hF);
        apb(1'b1, BTAV_OFF_CTRL, 32'h0000_0300, 4'h3);
        rdc(BTAV_OFF_TIME_WIN, ALL, 32'h0000_0000);
        apb(1'b1, BTAV_OFF_KEY, 32'h0000_0055, 4'h1);
        apb(1'b1, BTAV_OFF_CTRL, 32'h0000_0001, 4'h3);
        rdc(BTAV_OFF_CTRL, 32'h0000_0001, 32'h0000_0000);
        rdc(8'h20, ALL, 32'h0000_0000);
        chk({31'h0000_0000, se}, 32'h0000_0001);
        test_done;
    end
endmodule : test_btav_rtc
